// ---- icf_ctrl.sv ----
/*
 * Control register and primary status flags of a multi-master I2C
 * interface, reached over APB, with start/stop tracking of the bus.
 * Assumes a byte engine on core_clk reporting events as pulses, and
 * open-drain pad cells resolving scl from its output enable.
 */
// Overview of operation
// - Wait mode changes nothing; enabled interrupts still reach the processor.
// - Halt freezes all registers, withholds acknowledge, and raises no wake.
// - All events share one interrupt, gated by enable and global mask.
// - Control bits 7:6 always read zero.
// - Disabled block holds all bits but stop and busy reset and releases outputs.
// - Enabled block claims its two pins as alternate functions.
// - First enabling write sets only enable; second write sets the rest.
// - General call enable acknowledges address 00h, never 01h; cleared on disable.
// - Start bit requests start; cleared when sent or on disable.
// - Acknowledge enable returns acknowledges; cleared on disable.
// - Master stop bit requests stop; cleared when sent, not by disable.
// - Slave stop bit releases lines after byte done; software clears it.
// - Interrupt enable is writable, gates events, cleared on disable.
// - Clock held low while header, start, byte, match flags or post-address.
// - Event flag follows any event; cleared by sequences or disable.
// - Header flag set after first ten-bit byte; status two read, data write clears.
// - Direction bit shows transmit during byte done; clears with listed events.
// - Busy set on start, cleared on stop, tracked even when disabled.
// - Byte done set per transfer; status read then data access clears.
// - Address matched set on own or general call; status read clears.
// - Master select set by start write; cleared by stop, arbitration loss, disable.
// - Start sent set when start made; status read then data write clears.
`timescale 1ns/1ps
`include "icf_defines.svh"

module icf_ctrl (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Processor state
    input wire logic halt_mode,
    input wire logic global_imask,
    output logic irq,
    // Byte engine
    input wire icf_pkg::icf_evt_t evt,
    output icf_pkg::icf_req_t req,
    // Bus pins
    input wire logic scl_in,
    input wire logic sda_in,
    output logic scl_out,
    output logic scl_oe_n
);

    icf_pkg::icf_state_t st_reg;
    icf_pkg::icf_state_t st_next;

    // Byte address of a register index
    function automatic logic [7:0] byte_addr(input logic [7:0] idx);
        byte_addr = {idx[5:0], 2'b00};
    endfunction : byte_addr

    // Register byte in the low lane; upper lanes read zero
    function automatic logic [31:0] lane_word(input logic [7:0] b);
        lane_word = {24'h000000, b};
    endfunction : lane_word

    // Slave stop request frees the lines only once the byte is done
    function automatic logic slave_release(input icf_pkg::icf_state_t s);
        slave_release = s.stop_bit & ~s.master_select & s.byte_done;
    endfunction : slave_release

    // Flags that stretch the clock; error flags never do
    function automatic logic stretch_flags(input icf_pkg::icf_state_t s);
        stretch_flags = s.ten_bit_header_sent | s.start_sent | s.byte_done |
                        s.addr_matched | s.post_address_event;
    endfunction : stretch_flags

    // Every flag that raises the event bit
    function automatic logic any_event(input icf_pkg::icf_state_t s);
        any_event = s.byte_done | s.addr_matched | s.start_sent | s.ten_bit_header_sent |
                    s.post_address_event | s.ack_failure | s.stop_detected | s.arb_lost |
                    s.bus_error_flag;
    endfunction : any_event

    // A general call counts only while its enable is set
    function automatic logic gen_call_hit(input icf_pkg::icf_evt_t e, input logic en);
        gen_call_hit = e.gen_call & en;
    endfunction : gen_call_hit

    logic access;
    logic first_access;
    logic hit_cr;
    logic hit_s1;
    logic hit_s2;
    logic hit_dr;
    logic wr_cr;
    logic rd_s1;
    logic rd_s2;
    logic acc_dr;
    logic wr_dr;
    logic start_det;
    logic stop_det;
    logic [7:0] cr_view;
    logic [7:0] s1_view;
    logic [7:0] s2_view;

    always_comb
    begin
        st_next = st_reg;
        // Request completes on the edge where the registered pready is seen
        access = psel & penable & st_reg.pready;
        // The answer is registered, so every transfer has one wait state
        first_access = psel & penable & ~st_reg.pready;
        hit_cr = (paddr == byte_addr(`ICF_IDX_CONTROL));
        hit_s1 = (paddr == byte_addr(`ICF_IDX_STATUS1));
        hit_s2 = (paddr == byte_addr(`ICF_IDX_STATUS2));
        hit_dr = (paddr == byte_addr(`ICF_IDX_DATA));
        wr_cr = access & pwrite & hit_cr;
        rd_s1 = access & ~pwrite & hit_s1;
        rd_s2 = access & ~pwrite & hit_s2;
        acc_dr = access & hit_dr;
        wr_dr = acc_dr & pwrite;
        // Only the second stage of each synchroniser feeds the detectors
        start_det = st_reg.scl_prev & st_reg.scl_sync[1] & st_reg.sda_prev & ~st_reg.sda_sync[1];
        stop_det = st_reg.scl_prev & st_reg.scl_sync[1] & ~st_reg.sda_prev & st_reg.sda_sync[1];

        cr_view = {2'b00, st_reg.block_enable, st_reg.gen_call_enable, st_reg.start_bit,
                   st_reg.ack_enable, st_reg.stop_bit, st_reg.irq_enable};
        s1_view = {st_reg.event_flag, st_reg.ten_bit_header_sent, st_reg.xmit_direction,
                   st_reg.bus_busy, st_reg.byte_done, st_reg.addr_matched,
                   st_reg.master_select, st_reg.start_sent};
        s2_view = {3'b000, st_reg.ack_failure, st_reg.stop_detected, st_reg.arb_lost,
                   st_reg.bus_error_flag, st_reg.gen_call_seen};

        // Pin synchronisers and bus tracking run even while disabled
        st_next.scl_sync = {st_reg.scl_sync[0], scl_in};
        st_next.sda_sync = {st_reg.sda_sync[0], sda_in};
        st_next.scl_prev = st_reg.scl_sync[1];
        st_next.sda_prev = st_reg.sda_sync[1];
        if (start_det)
        begin
            st_next.bus_busy = 1'b1;
        end
        else if (stop_det)
        begin
            st_next.bus_busy = 1'b0;
        end

        // APB answer: one wait cycle, then pready for one cycle
        st_next.pready = first_access;
        st_next.pslverr = 1'b0;
        st_next.prdata = `ICF_RST_WORD;
        if (first_access)
        begin
            st_next.pslverr = ~(hit_cr | hit_s1 | hit_s2 | hit_dr);
            if (!pwrite)
            begin
                if (hit_cr)
                begin
                    st_next.prdata = lane_word(cr_view);
                end
                else if (hit_s1)
                begin
                    st_next.prdata = lane_word(s1_view);
                end
                else if (hit_s2)
                begin
                    st_next.prdata = lane_word(s2_view);
                end
            end
        end

        // Two-step clearing memory: any completed access ends it
        if (access)
        begin
            st_next.status_one_read = rd_s1;
            st_next.status_two_read = rd_s2;
        end

        // Clearing by software sequences
        if (rd_s1)
        begin
            st_next.addr_matched = 1'b0;
        end
        if (acc_dr & st_reg.status_one_read)
        begin
            st_next.byte_done = 1'b0;
            st_next.xmit_direction = 1'b0;
        end
        if (wr_dr & st_reg.status_one_read)
        begin
            st_next.start_sent = 1'b0;
        end
        if (wr_dr & st_reg.status_two_read)
        begin
            st_next.ten_bit_header_sent = 1'b0;
        end
        if (wr_cr & st_reg.status_one_read)
        begin
            st_next.post_address_event = 1'b0;
        end
        if (rd_s2)
        begin
            st_next.ack_failure = 1'b0;
            st_next.stop_detected = 1'b0;
            st_next.arb_lost = 1'b0;
            st_next.bus_error_flag = 1'b0;
        end

        // Control register write
        if (wr_cr)
        begin
            st_next.block_enable = pwdata[`ICF_CR_BLOCK_EN];
            st_next.stop_bit = pwdata[`ICF_CR_STOP];
            if (st_reg.block_enable)
            begin
                st_next.gen_call_enable = pwdata[`ICF_CR_GC_EN];
                st_next.start_bit = pwdata[`ICF_CR_START];
                st_next.ack_enable = pwdata[`ICF_CR_ACK];
                st_next.irq_enable = pwdata[`ICF_CR_IRQ_EN];
                if (pwdata[`ICF_CR_START] & ~st_reg.bus_busy)
                begin
                    st_next.master_select = 1'b1;
                end
            end
            else
            begin
                // Enabling write only raises the enable; the rest waits
                st_next.stop_bit = st_reg.stop_bit;
            end
        end

        // Hardware events set flags; a set beats a same-cycle clearing sequence
        if (st_reg.block_enable)
        begin
            if (evt.start_sent)
            begin
                st_next.start_sent = 1'b1;
                st_next.start_bit = 1'b0;
            end
            if (evt.header_sent)
            begin
                st_next.ten_bit_header_sent = 1'b1;
            end
            if (evt.addr_sent)
            begin
                st_next.post_address_event = 1'b1;
            end
            if (evt.byte_done)
            begin
                st_next.byte_done = 1'b1;
                st_next.xmit_direction = evt.byte_was_tx;
            end
            if (evt.addr_match | gen_call_hit(evt, st_reg.gen_call_enable))
            begin
                st_next.addr_matched = 1'b1;
            end
            if (gen_call_hit(evt, st_reg.gen_call_enable))
            begin
                st_next.gen_call_seen = 1'b1;
            end
            if (evt.stop_sent & st_reg.master_select)
            begin
                st_next.stop_bit = 1'b0;
            end
            if (evt.ack_fail)
            begin
                st_next.ack_failure = 1'b1;
            end
            if (evt.bus_error)
            begin
                st_next.bus_error_flag = 1'b1;
            end
            if (stop_det)
            begin
                st_next.stop_detected = ~st_reg.master_select;
                st_next.master_select = 1'b0;
                st_next.xmit_direction = 1'b0;
                st_next.gen_call_seen = 1'b0;
            end
            if (evt.arb_lost)
            begin
                st_next.arb_lost = 1'b1;
                st_next.master_select = 1'b0;
                st_next.xmit_direction = 1'b0;
            end
        end

        st_next.event_flag = any_event(st_next);

        // Disabled: everything but stop and bus tracking held reset
        if (!st_next.block_enable)
        begin
            st_next.gen_call_enable = 1'b0;
            st_next.start_bit = 1'b0;
            st_next.ack_enable = 1'b0;
            st_next.irq_enable = 1'b0;
            st_next.ten_bit_header_sent = 1'b0;
            st_next.xmit_direction = 1'b0;
            st_next.byte_done = 1'b0;
            st_next.addr_matched = 1'b0;
            st_next.master_select = 1'b0;
            st_next.start_sent = 1'b0;
            st_next.post_address_event = 1'b0;
            st_next.event_flag = 1'b0;
            st_next.ack_failure = 1'b0;
            st_next.stop_detected = 1'b0;
            st_next.arb_lost = 1'b0;
            st_next.bus_error_flag = 1'b0;
            st_next.gen_call_seen = 1'b0;
        end

        // Outputs, all taken from next state so they leave flops
        st_next.scl_oe_n = ~(st_next.block_enable &
                             stretch_flags(st_next) &
                             ~slave_release(st_next));
        st_next.req.pins_alt_sel = st_next.block_enable;
        st_next.req.start_req = st_next.start_bit;
        st_next.req.stop_req = st_next.block_enable & st_next.stop_bit &
                               st_next.master_select;
        st_next.req.release_lines = ~st_next.block_enable |
                                    slave_release(st_next);
        st_next.req.ack_en = st_next.ack_enable & ~halt_mode;
        st_next.req.gen_call_en = st_next.gen_call_enable & ~halt_mode;
        // Wait mode is invisible here; the interrupt alone wakes the core
        st_next.irq = st_next.irq_enable & st_next.event_flag & ~global_imask &
                      ~halt_mode;

        // Halt freezes every register; only acknowledge and irq are dropped
        // Pin samplers freeze too, so a pin edge made during halt shows on resume
        if (halt_mode)
        begin
            st_next = st_reg;
            st_next.req.ack_en = 1'b0;
            st_next.req.gen_call_en = 1'b0;
            st_next.irq = 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_reg <= '0;
            st_reg.scl_sync <= 2'b11;
            st_reg.sda_sync <= 2'b11;
            st_reg.scl_prev <= 1'b1;
            st_reg.sda_prev <= 1'b1;
            st_reg.scl_oe_n <= 1'b1;
            st_reg.req.release_lines <= 1'b1;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign prdata = st_reg.prdata;
    assign pready = st_reg.pready;
    assign pslverr = st_reg.pslverr;
    assign irq = st_reg.irq;
    assign req = st_reg.req;
    assign scl_oe_n = st_reg.scl_oe_n;
    // Open-drain: only ever pulls low
    assign scl_out = 1'b0;

endmodule : icf_ctrl

// ---- icf_defines.svh ----
/*
 * Constants of the bus control and status block: register indexes,
 * field positions and reset values.
 * Assumes it is included by bare name from design files.
 */
`ifndef ICF_DEFINES_SVH
`define ICF_DEFINES_SVH

// Register indexes; the byte address is four times the index
`define ICF_IDX_CONTROL 8'h28
`define ICF_IDX_STATUS1 8'h29
`define ICF_IDX_STATUS2 8'h2A
`define ICF_IDX_DATA 8'h2E

// Control register fields
`define ICF_CR_BLOCK_EN 5
`define ICF_CR_GC_EN 4
`define ICF_CR_START 3
`define ICF_CR_ACK 2
`define ICF_CR_STOP 1
`define ICF_CR_IRQ_EN 0

// Primary status fields
`define ICF_S1_EVENT 7
`define ICF_S1_TEN_BIT 6
`define ICF_S1_XMIT 5
`define ICF_S1_BUSY 4
`define ICF_S1_BYTE_DONE 3
`define ICF_S1_ADDR_MATCH 2
`define ICF_S1_MASTER 1
`define ICF_S1_START_SENT 0

// Secondary status fields
`define ICF_S2_ACK_FAIL 4
`define ICF_S2_STOP_DET 3
`define ICF_S2_ARB_LOST 2
`define ICF_S2_BUS_ERR 1
`define ICF_S2_GEN_CALL 0

// Reset values
`define ICF_RST_BYTE 8'h00
`define ICF_RST_WORD 32'h0000_0000

`endif

// ---- icf_pkg.sv ----
/*
 * Types of the bus control and status block.
 * Assumes icf_defines.svh carries every number.
 */
package icf_pkg;

    // Events reported by the byte engine, one-cycle pulses
    typedef struct packed {
        logic byte_done;
        logic byte_was_tx;
        logic addr_match;
        logic gen_call;
        logic start_sent;
        logic header_sent;
        logic addr_sent;
        logic stop_sent;
        logic ack_fail;
        logic arb_lost;
        logic bus_error;
    } icf_evt_t;

    // Requests to the byte engine and the pins
    typedef struct packed {
        logic start_req;
        logic stop_req;
        logic ack_en;
        logic gen_call_en;
        logic release_lines;
        logic pins_alt_sel;
    } icf_req_t;

    // Whole state of the block
    typedef struct packed {
        logic [1:0] scl_sync;
        logic [1:0] sda_sync;
        logic sda_prev;
        logic scl_prev;
        logic block_enable;
        logic gen_call_enable;
        logic start_bit;
        logic ack_enable;
        logic stop_bit;
        logic irq_enable;
        logic ten_bit_header_sent;
        logic xmit_direction;
        logic bus_busy;
        logic byte_done;
        logic addr_matched;
        logic master_select;
        logic start_sent;
        logic post_address_event;
        logic event_flag;
        logic ack_failure;
        logic stop_detected;
        logic arb_lost;
        logic bus_error_flag;
        logic gen_call_seen;
        logic status_one_read;
        logic status_two_read;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic scl_oe_n;
        logic irq;
        icf_req_t req;
    } icf_state_t;

endpackage : icf_pkg

// ---- icf_bus_peer.sv ----
/*
 * Model of the other masters and slaves on the two-wire bus.
 * Assumes pull-ups on both lines; the bench commands start and stop.
 */
`timescale 1ns/1ps
module icf_bus_peer (
    // Clock
    input wire logic core_clk,
    // Commands from the bench
    input wire logic make_start,
    input wire logic make_stop,
    // Device clock driver
    input wire logic scl_out,
    input wire logic scl_oe_n,
    // Resolved lines
    output logic scl_line,
    output logic sda_line
);
    initial sda_line = 1'b1;
    // Peer never pulls scl, so a low line is the device stretching
    assign scl_line = scl_oe_n | scl_out;
    // Sda moves on command whatever scl does: start falls, stop rises
    always @(posedge core_clk)
    begin
        if (make_start)
            sda_line <= 1'b0;
        else if (make_stop)
            sda_line <= 1'b1;
    end
endmodule : icf_bus_peer

// ---- icf_ctrl_assertions.sv ----
/*
 * Port assertions for icf_ctrl.
 * Assumes one clock domain; bound onto every icf_ctrl instance.
 */
`timescale 1ns/1ps
module icf_ctrl_assertions (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    // Processor and engine
    input wire logic halt_mode,
    input wire logic global_imask,
    input wire logic irq,
    input wire icf_pkg::icf_evt_t evt,
    input wire icf_pkg::icf_req_t req,
    // Pins
    input wire logic scl_oe_n
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);
    sequence s_first_access;
        psel && penable && !pready && !halt_mode;
    endsequence
    sequence s_live_start;
        req.pins_alt_sel && evt.start_sent && !halt_mode;
    endsequence
    AST_APB_ONE_WAIT: assert property (s_first_access |=> pready)
        else $error("APB answer late");
    AST_PREADY_PULSE: assert property (pready && !halt_mode |=> !pready)
        else $error("pready longer than one cycle");
    AST_CR_TOP_ZERO: assert property (pready && !pwrite && paddr == 8'hA0 |-> prdata[31:6] == 26'h0)
        else $error("control top bits not zero");
    AST_DISABLED_RELEASE: assert property (!req.pins_alt_sel |-> req.release_lines && scl_oe_n && !req.ack_en && !req.gen_call_en && !req.start_req && !req.stop_req)
        else $error("disabled block still drives");
    AST_IMASK_NO_IRQ: assert property (global_imask && $past(global_imask) |-> !irq)
        else $error("irq while masked");
    AST_HALT_NO_IRQ: assert property (halt_mode && $past(halt_mode) |-> !irq)
        else $error("irq in halt");
    AST_DISABLED_NO_IRQ: assert property (irq |-> $past(req.pins_alt_sel))
        else $error("irq while disabled");
    AST_START_STRETCH: assert property (s_live_start |=> !scl_oe_n)
        else $error("no stretch after start");
    AST_HEADER_STRETCH: assert property (req.pins_alt_sel && evt.header_sent && !halt_mode |=> !scl_oe_n)
        else $error("no stretch after header");
    AST_START_CLEARS: assert property (s_live_start ##0 req.start_req |=> !req.start_req)
        else $error("start bit kept after start sent");
endmodule : icf_ctrl_assertions
bind icf_ctrl icf_ctrl_assertions chk_u (.core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .halt_mode(halt_mode),
    .global_imask(global_imask), .irq(irq), .evt(evt), .req(req), .scl_oe_n(scl_oe_n));

// ---- icf_ctrl_test.sv ----
/*
 * Self-checking bench for icf_ctrl: registers, flags, clearing, interrupts, halt, disable, busy.
 * Assumes icf_bus_peer and the checker are compiled first.
 */
`timescale 1ns/1ps
`include "icf_defines.svh"
module icf_ctrl_test;
    logic core_clk, rst_n, psel, penable, pwrite, pready, pslverr, halt_mode, global_imask, irq;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic scl_line, sda_line, scl_out, scl_oe_n, make_start, make_stop, err, tx;
    logic [7:0] d;
    icf_pkg::icf_evt_t evt, e;
    icf_pkg::icf_req_t req;
    int mismatches, n_checks;
    icf_ctrl dut_u (.core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .halt_mode(halt_mode), .global_imask(global_imask), .irq(irq), .evt(evt), .req(req),
        .scl_in(scl_line), .sda_in(sda_line), .scl_out(scl_out), .scl_oe_n(scl_oe_n));
    icf_bus_peer peer_u (.core_clk(core_clk), .make_start(make_start), .make_stop(make_stop),
        .scl_out(scl_out), .scl_oe_n(scl_oe_n), .scl_line(scl_line), .sda_line(sda_line));
    task automatic final_report();
        $display("Checks %0d, mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : final_report
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            $display("Error at %0t: got %h expected %h", $time, got, exp);
            mismatches++;
        end
    endtask : check
    // Request held until pready is seen high at a rising edge
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
        int n;
        n = 0;
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx[5:0], 2'b00};
        pwdata <= {24'h0, wd};
        @(posedge core_clk);
        penable <= 1'b1;
        do
        begin
            @(posedge core_clk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1)
        begin
            mismatches++;
            final_report();
        end
    endtask : apb
    task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp);
        apb(1'b0, idx, 8'h00);
        check(rd, exp);
    endtask : rd_chk
    task automatic pulse(input icf_pkg::icf_evt_t v);
        @(posedge core_clk);
        evt <= v;
        @(posedge core_clk);
        evt <= '0;
        repeat (3) @(posedge core_clk);
    endtask : pulse
    task automatic bus_cond(input logic s);
        @(posedge core_clk);
        make_start <= s;
        make_stop <= !s;
        @(posedge core_clk);
        make_start <= 1'b0;
        make_stop <= 1'b0;
        repeat (6) @(posedge core_clk);
    endtask : bus_cond
    // Status one after a byte: event, direction, byte done
    function automatic logic [31:0] sr1_byte(input logic t);
        return {24'h0, 2'b10, t, 2'b01, 3'b000};
    endfunction : sr1_byte
    initial
    begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    initial
    begin
        {rst_n, psel, penable, pwrite, halt_mode, global_imask, make_start, make_stop} = '0;
        paddr = '0;
        pwdata = '0;
        evt = '0;
        mismatches = 0;
        n_checks = 0;
        void'($urandom(32'hFC0C));
        repeat (5) @(posedge core_clk);
        rst_n <= 1'b1;
        rd_chk(`ICF_IDX_CONTROL, 32'h0);
        rd_chk(`ICF_IDX_STATUS1, 32'h0);
        apb(1'b0, 8'h2B, 8'h00);
        check(err, 1'b1);
        apb(1'b1, `ICF_IDX_STATUS1, 8'hFF);
        rd_chk(`ICF_IDX_STATUS1, 32'h0);
        $display("test reset and map done");
        apb(1'b1, `ICF_IDX_CONTROL, 8'hFF);
        rd_chk(`ICF_IDX_CONTROL, 32'h20);
        d = (8'($urandom) & 8'h35) | 8'h20;
        apb(1'b1, `ICF_IDX_CONTROL, d);
        rd_chk(`ICF_IDX_CONTROL, {24'h0, d});
        check(req.ack_en, d[2]);
        check(req.gen_call_en, d[4]);
        check(req.pins_alt_sel, 1'b1);
        apb(1'b1, `ICF_IDX_CONTROL, 8'h27);
        apb(1'b1, `ICF_IDX_CONTROL, 8'h02);
        rd_chk(`ICF_IDX_CONTROL, 32'h02);
        apb(1'b1, `ICF_IDX_CONTROL, 8'h20);
        rd_chk(`ICF_IDX_CONTROL, 32'h22);
        apb(1'b1, `ICF_IDX_CONTROL, 8'h21);
        rd_chk(`ICF_IDX_CONTROL, 32'h21);
        $display("test enable done");
        for (int i = 0; i < 8; i++)
        begin
            tx = 1'($urandom);
            e = '0;
            e.byte_done = 1'b1;
            e.byte_was_tx = tx;
            pulse(e);
            check(scl_oe_n, 1'b0);
            check(irq, 1'b1);
            rd_chk(`ICF_IDX_STATUS1, sr1_byte(tx));
            if (i == 0)
                apb(1'b0, `ICF_IDX_CONTROL, 8'h00);
            apb(i[0], `ICF_IDX_DATA, 8'hFF);
            if (i == 0)
            begin
                rd_chk(`ICF_IDX_STATUS1, sr1_byte(tx));
                apb(1'b1, `ICF_IDX_DATA, 8'hFF);
            end
            rd_chk(`ICF_IDX_STATUS1, 32'h0);
            check(scl_oe_n, 1'b1);
            check(irq, 1'b0);
        end
        $display("test byte done done");
        global_imask <= 1'b1;
        e = '0;
        e.addr_match = 1'b1;
        pulse(e);
        check(irq, 1'b0);
        global_imask <= 1'b0;
        repeat (3) @(posedge core_clk);
        check(irq, 1'b1);
        rd_chk(`ICF_IDX_STATUS1, 32'h84);
        rd_chk(`ICF_IDX_STATUS1, 32'h0);
        apb(1'b1, `ICF_IDX_CONTROL, 8'h30);
        e = '0;
        e.gen_call = 1'b1;
        pulse(e);
        check(irq, 1'b0);
        rd_chk(`ICF_IDX_STATUS1, 32'h84);
        rd_chk(`ICF_IDX_STATUS2, 32'h01);
        apb(1'b1, `ICF_IDX_CONTROL, 8'h29);
        @(negedge core_clk);
        check(req.start_req, 1'b1);
        rd_chk(`ICF_IDX_STATUS1, 32'h02);
        e = '0;
        e.start_sent = 1'b1;
        pulse(e);
        rd_chk(`ICF_IDX_CONTROL, 32'h21);
        rd_chk(`ICF_IDX_STATUS1, 32'h83);
        apb(1'b1, `ICF_IDX_DATA, 8'hA4);
        rd_chk(`ICF_IDX_STATUS1, 32'h02);
        e = '0;
        e.header_sent = 1'b1;
        pulse(e);
        rd_chk(`ICF_IDX_STATUS1, 32'hC2);
        apb(1'b0, `ICF_IDX_STATUS2, 8'h00);
        apb(1'b1, `ICF_IDX_DATA, 8'h5A);
        rd_chk(`ICF_IDX_STATUS1, 32'h02);
        e = '0;
        e.addr_sent = 1'b1;
        pulse(e);
        rd_chk(`ICF_IDX_STATUS1, 32'h82);
        apb(1'b1, `ICF_IDX_CONTROL, 8'h23);
        @(negedge core_clk);
        check(req.stop_req, 1'b1);
        rd_chk(`ICF_IDX_STATUS1, 32'h02);
        e = '0;
        e.stop_sent = 1'b1;
        pulse(e);
        rd_chk(`ICF_IDX_CONTROL, 32'h21);
        bus_cond(1'b1);
        rd_chk(`ICF_IDX_STATUS1, 32'h12);
        bus_cond(1'b0);
        rd_chk(`ICF_IDX_STATUS1, 32'h0);
        $display("test master flags done");
        halt_mode <= 1'b1;
        e = '0;
        e.byte_done = 1'b1;
        pulse(e);
        check(irq, 1'b0);
        check(scl_oe_n, 1'b1);
        halt_mode <= 1'b0;
        rd_chk(`ICF_IDX_STATUS1, 32'h0);
        apb(1'b1, `ICF_IDX_CONTROL, 8'h23);
        pulse(e);
        check(req.release_lines, 1'b1);
        check(scl_oe_n, 1'b1);
        apb(1'b1, `ICF_IDX_CONTROL, 8'h21);
        apb(1'b1, `ICF_IDX_CONTROL, 8'h00);
        rd_chk(`ICF_IDX_STATUS1, 32'h0);
        check(irq, 1'b0);
        bus_cond(1'b1);
        rd_chk(`ICF_IDX_STATUS1, 32'h10);
        bus_cond(1'b0);
        rd_chk(`ICF_IDX_STATUS1, 32'h0);
        $display("test halt and disable done");
        final_report();
    end
endmodule : icf_ctrl_test
